// *** core/bcl_cfg.svh ***
// Constants of the board configuration loader: timing, widths, offsets.
// Assumes a 100 MHz ref_clk; included by the design files only.
`ifndef BCL_CFG_SVH
`define BCL_CFG_SVH

// Clock rates
`define BCL_CLK_HZ        100000000
`define BCL_CFG_HZ        12000000
// Serial configuration clock: whole period rounded up, split high/low
`define BCL_CFG_PER_CYC   ((`BCL_CLK_HZ + `BCL_CFG_HZ - 1) / `BCL_CFG_HZ)
`define BCL_CFG_HI_CYC    ((`BCL_CFG_PER_CYC + 1) / 2)
`define BCL_CFG_LO_CYC    (`BCL_CFG_PER_CYC / 2)

// Flash read access time, rounded up to cycles
`define BCL_FLASH_ACC_NS  100
`define BCL_FLASH_ACC_CYC ((`BCL_FLASH_ACC_NS * 100 + 999) / 1000)
// Extra cycles for the two-stage data synchroniser
`define BCL_SYNC_CYC      2

// Target configuration request pulse, rounded up to cycles
`define BCL_PULSE_NS      2000
`define BCL_PULSE_CYC     ((`BCL_PULSE_NS * 100 + 999) / 1000)
// Wait for the target status line after the pulse
`define BCL_STATUS_TO_NS  100000
// Wait for the done line once the image is out
`define BCL_DONE_NS       10000
`define BCL_DONE_CYC      ((`BCL_DONE_NS * 100 + 999) / 1000)

// Widths
`define BCL_FADDR_W       26
`define BCL_WCNT_W        24
`define BCL_TMR_W         16
`define BCL_WORD_W        16
`define BCL_FIFO_DEPTH    32

// Display register offsets on the shared bus
`define BCL_REG_DISP_CTRL 2'h0
`define BCL_REG_DISP_VAL  2'h1
`define BCL_REG_STATUS    2'h2
// Display control fields
`define BCL_DC_OVR_BIT    0
`define BCL_DC_PWR_BIT    1
// Reset values
`define BCL_DISP_CTRL_RST 2'h0
`define BCL_DISP_VAL_RST  16'h0000

`endif

// *** core/bcl_pkg.sv ***
// Types of the board configuration loader.
// Assumes nothing of its surroundings.
package bcl_pkg;

	// Loader sequence, Gray codes along the usual path
	typedef enum logic [2:0] {
		BCL_IDLE  = 3'h0,
		BCL_PULSE = 3'h1,
		BCL_WSTAT = 3'h3,
		BCL_LOAD  = 3'h2,
		BCL_DWAIT = 3'h6,
		BCL_GOOD  = 3'h7,
		BCL_FAIL  = 3'h5
	} bcl_state_t;

	// Board settings switches, raw levels (on reads 0)
	typedef struct packed {
		logic loader_en;
		logic show_power;
		logic tgt_byp;
		logic pa_byp;
		logic pb_byp;
		logic ctrl_dis;
	} bcl_sw_t;

	// Status indicators, active high
	typedef struct packed {
		logic loading;
		logic error;
		logic factory;
		logic user;
		logic sram_act;
		logic flash_act;
	} bcl_led_t;

	// Scan chain steering
	typedef struct packed {
		logic tgt_in;
		logic pa_in;
		logic pb_in;
		logic ctrl_scan_en;
		logic cable_en;
	} bcl_chain_t;

	// Power display control
	typedef struct packed {
		logic        override;
		logic        show_power;
		logic [15:0] value;
	} bcl_disp_t;

endpackage : bcl_pkg

// *** core/bcl_fifo.sv ***
// Word FIFO between the flash fetcher and the serializer.
// Assumes one clock; valid/ready on both sides.
`timescale 1ns/100ps
module bcl_fifo #(
	parameter int W = 16,
	parameter int D = 32
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic         flush,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rp_r];

	always_ff @(posedge ref_clk) begin
		if (push)
			mem[wp_r] <= in_data;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (flush) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_count_step: assert property (@(posedge ref_clk) disable iff (!nrst)
		push && !pop && !flush |=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("fifo count did not step on a push");

endmodule : bcl_fifo

// *** core/bcl_ser.sv ***
// Serializer: 16-bit words out as a passive serial stream with its clock.
// Assumes words from a valid/ready source on the same clock.
`timescale 1ns/100ps
`include "bcl_cfg.svh"
module bcl_ser (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        en,
	// Word input
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [15:0] in_data,
	// Serial output
	output logic             busy,
	output logic             cfg_clk,
	output logic             cfg_dat
);
	localparam logic [3:0] HI = 4'(`BCL_CFG_HI_CYC - 1);
	localparam logic [3:0] LO = 4'(`BCL_CFG_LO_CYC - 1);

	logic [15:0] sh_r;
	logic [4:0]  bits_r;
	logic [3:0]  pc_r;
	logic        clk_r;
	logic        dat_r;
	logic        take;

	assign in_ready = en && (bits_r == '0) && !clk_r;
	assign take     = in_valid && in_ready;
	assign busy     = (bits_r != '0);
	assign cfg_clk  = clk_r;
	assign cfg_dat  = dat_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sh_r   <= '0;
			bits_r <= '0;
			pc_r   <= '0;
			clk_r  <= 1'b0;
			dat_r  <= 1'b0;
		end else if (!en) begin
			bits_r <= '0;
			pc_r   <= '0;
			clk_r  <= 1'b0;
		end else if (take) begin
			sh_r   <= in_data;
			dat_r  <= in_data[0];
			bits_r <= 5'h10;
			pc_r   <= LO;
		end else if (pc_r != '0) begin
			pc_r <= pc_r - 1'b1;
		end else if (clk_r) begin
			clk_r  <= 1'b0;
			bits_r <= bits_r - 1'b1;
			sh_r   <= {1'b0, sh_r[15:1]};
			dat_r  <= sh_r[1];
			pc_r   <= LO;
		end else if (bits_r != '0) begin
			clk_r <= 1'b1;
			pc_r  <= HI;
		end
	end

	logic in_bit0;
	assign in_bit0 = in_data[0];

	a_first_bit_lsb: assert property (@(posedge ref_clk) disable iff (!nrst)
		take |=> cfg_dat == $past(in_bit0))
		else $error("first serial bit is not the word's lsb");

	a_clk_high_time: assert property (@(posedge ref_clk)
		disable iff (!nrst || !en)
		$rose(cfg_clk) |-> cfg_clk [*5] ##1 !cfg_clk)
		else $error("serial clock high time wrong");

endmodule : bcl_ser

// *** core/bcl_top.sv ***
// Board configuration loader: flash to passive serial, indicators, switches.
// Assumes raw board pins outside ref_clk's domain; a 100 MHz ref_clk.
`timescale 1ns/100ps
`include "bcl_cfg.svh"

// What this block does
// - Load at power-up, reconfigure or factory button
// - Fetch flash as 16-bit words, serialize
// - Drive serial clock and data at no more than 12 MHz (9-cycle period)
// - Eight images from rotary switch, first eight
// - Each position maps to distinct flash offset
// - Loader runs only while enable switch reads 1
// - Switch on reads 0, off reads 1
// - Loading indicator while configuring the target
// - Error indicator when configuration fails
// - Factory indicator after factory image loaded
// - User indicator after other image loaded
// - SRAM activity indicator during SRAM access
// - Flash activity indicator during flash access
// - Display quantity switch: 0 voltage, 1 power
// - Display also controllable by target registers
// - Target bypass switch 1 puts target in chain
// - Port A in chain when 1 and installed
// - Port B in chain when 1 and installed
// - Controller enable 1 disables scan and cable
// - Factory button loads image at flash base
// - Reconfigure and system buttons reset controller
module bcl_top #(
	parameter logic [23:0] IMG_WORDS  = 24'h000400,
	parameter logic [25:0] IMG_STRIDE = 26'h0400000,
	parameter logic [15:0] STATUS_TO  = 16'(`BCL_STATUS_TO_NS * 100 / 1000)
) (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	// Push buttons, raw, active low
	input  wire logic                    btn_reconf_n,
	input  wire logic                    btn_factory_n,
	input  wire logic                    btn_sysrst_n,
	// Switches, raw
	input  wire bcl_pkg::bcl_sw_t        sw_pins,
	input  wire logic [3:0]              img_sel_pins,
	input  wire logic                    pa_present_n,
	input  wire logic                    pb_present_n,
	// Shared flash bus
	input  wire logic [15:0]             bus_d_i,
	output logic [25:0]                  flash_addr_o,
	output logic                         flash_ce_n_o,
	output logic                         flash_oe_n_o,
	output logic                         flash_bus_oe_n,
	input  wire logic                    tgt_flash_ce_n,
	input  wire logic                    sram_ce_n,
	// Target configuration port
	output logic                         serial_cfg_clock,
	output logic                         serial_cfg_data,
	output logic                         tgt_config_n,
	input  wire logic                    tgt_status_n,
	input  wire logic                    tgt_conf_done,
	// Display registers on the shared bus
	input  wire logic                    reg_cs_n,
	input  wire logic                    reg_we_n,
	input  wire logic                    reg_oe_n,
	input  wire logic [1:0]              reg_addr,
	output logic [15:0]                  reg_rd_data,
	output logic                         reg_rd_oe_n,
	// Indicators, chain steering, display
	output bcl_pkg::bcl_led_t            leds,
	output bcl_pkg::bcl_chain_t          chain,
	output bcl_pkg::bcl_disp_t           disp
);
	import bcl_pkg::*;

	localparam int          PW       = 40;
	localparam logic [15:0] PULSE_C  = 16'(`BCL_PULSE_CYC - 1);
	localparam logic [15:0] DONE_C   = 16'(`BCL_DONE_CYC - 1);
	localparam logic [4:0]  FETCH_C  = 5'(`BCL_FLASH_ACC_CYC + `BCL_SYNC_CYC);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [PW-1:0] pin_v;
	logic [PW-1:0] s1_r;
	logic [PW-1:0] s2_r;

	assign pin_v = {btn_reconf_n, btn_factory_n, btn_sysrst_n, sw_pins,
		img_sel_pins, pa_present_n, pb_present_n, bus_d_i, tgt_flash_ce_n,
		sram_ce_n, tgt_status_n, tgt_conf_done, reg_cs_n, reg_we_n, reg_oe_n,
		reg_addr};

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_r <= '1;
			s2_r <= '1;
		end else begin
			s1_r <= pin_v;
			s2_r <= s1_r;
		end
	end

	logic        reconf_n_s;
	logic        factory_n_s;
	logic        sysrst_n_s;
	bcl_sw_t     sw_s;
	logic [3:0]  sel_s;
	logic        pa_pres_n_s;
	logic        pb_pres_n_s;
	logic [15:0] d_s;
	logic        tfce_n_s;
	logic        sram_n_s;
	logic        status_n_s;
	logic        done_s;
	logic        cs_n_s;
	logic        we_n_s;
	logic        oe_n_s;
	logic [1:0]  addr_s;

	// Switch levels are used as read: on is 0, off is 1
	assign {reconf_n_s, factory_n_s, sysrst_n_s, sw_s, sel_s, pa_pres_n_s,
		pb_pres_n_s, d_s, tfce_n_s, sram_n_s, status_n_s, done_s, cs_n_s,
		we_n_s, oe_n_s, addr_s} = s2_r;

	////////////////////////////////////////////////////////////////////////////
	// Start requests

	logic       ctl_rst;
	logic       fac_prev_r;
	logic       start_pend_r;
	logic       fac_req_r;
	logic       go;
	logic       go_fac;
	bcl_state_t state_r;
	logic       rest;
	logic [1:0] warm_r;

	assign ctl_rst = !reconf_n_s || !sysrst_n_s;
	assign rest    = (state_r == BCL_IDLE) || (state_r == BCL_GOOD)
		|| (state_r == BCL_FAIL);
	assign go      = rest && sw_s.loader_en && !ctl_rst
		&& warm_r[1] && (start_pend_r || fac_req_r);
	assign go_fac  = fac_req_r;

	// Hold starts until the synchronisers carry real pin levels
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			warm_r <= 2'h0;
		else
			warm_r <= {warm_r[0], 1'b1};
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			start_pend_r <= 1'b1;
			fac_req_r    <= 1'b0;
			fac_prev_r   <= 1'b1;
		end else begin
			fac_prev_r <= factory_n_s;
			if (ctl_rst) begin
				start_pend_r <= 1'b1;
				fac_req_r    <= 1'b0;
			end else if (go) begin
				start_pend_r <= 1'b0;
				fac_req_r    <= 1'b0;
			end else if (fac_prev_r && !factory_n_s) begin
				fac_req_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Loader sequence

	logic [15:0] tmr_r;
	logic [23:0] left_r;
	logic [25:0] faddr_r;
	logic        fac_img_r;
	logic        all_out;
	logic        f_busy_r;
	logic [4:0]  f_cnt_r;
	logic        fifo_in_valid;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_out_ready;
	logic [15:0] fifo_out_data;
	logic        ser_busy;
	logic        ser_en;
	logic        push_done;

	assign ser_en  = (state_r == BCL_LOAD);
	assign all_out = (left_r == '0) && !f_busy_r && !fifo_out_valid
		&& !ser_busy;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r   <= BCL_IDLE;
			tmr_r     <= '0;
			fac_img_r <= 1'b0;
		end else if (ctl_rst || (!rest && !sw_s.loader_en)) begin
			state_r <= BCL_IDLE;
		end else begin
			unique case (state_r)
				BCL_IDLE, BCL_GOOD, BCL_FAIL: begin
					if (go) begin
						fac_img_r <= go_fac;
						tmr_r     <= PULSE_C;
						if (!go_fac && sel_s[3])
							state_r <= BCL_FAIL;
						else
							state_r <= BCL_PULSE;
					end
				end
				BCL_PULSE: begin
					if (tmr_r == '0) begin
						tmr_r   <= STATUS_TO;
						state_r <= BCL_WSTAT;
					end else
						tmr_r <= tmr_r - 1'b1;
				end
				BCL_WSTAT: begin
					if (status_n_s)
						state_r <= BCL_LOAD;
					else if (tmr_r == '0)
						state_r <= BCL_FAIL;
					else
						tmr_r <= tmr_r - 1'b1;
				end
				BCL_LOAD: begin
					tmr_r <= DONE_C;
					if (!status_n_s)
						state_r <= BCL_FAIL;
					else if (all_out)
						state_r <= BCL_DWAIT;
				end
				BCL_DWAIT: begin
					if (done_s)
						state_r <= BCL_GOOD;
					else if (tmr_r == '0)
						state_r <= BCL_FAIL;
					else
						tmr_r <= tmr_r - 1'b1;
				end
				default: state_r <= BCL_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flash fetcher

	assign fifo_in_valid = f_busy_r && (f_cnt_r == '0);
	assign push_done     = fifo_in_valid && fifo_in_ready;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			faddr_r  <= '0;
			left_r   <= '0;
			f_busy_r <= 1'b0;
			f_cnt_r  <= '0;
		end else if (go) begin
			faddr_r  <= go_fac ? '0
				: 26'({23'h0, sel_s[2:0]} * IMG_STRIDE);
			left_r   <= IMG_WORDS;
			f_busy_r <= 1'b0;
		end else if (state_r != BCL_LOAD) begin
			f_busy_r <= 1'b0;
		end else if (!f_busy_r && left_r != '0 && fifo_in_ready) begin
			f_busy_r <= 1'b1;
			f_cnt_r  <= FETCH_C;
		end else if (push_done) begin
			f_busy_r <= 1'b0;
			faddr_r  <= faddr_r + 1'b1;
			left_r   <= left_r - 1'b1;
		end else if (f_busy_r && f_cnt_r != '0) begin
			f_cnt_r <= f_cnt_r - 1'b1;
		end
	end

	bcl_fifo #(
		.W (`BCL_WORD_W),
		.D (`BCL_FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.flush     (go),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (d_s),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	bcl_ser u_ser (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.en       (ser_en),
		.in_valid (fifo_out_valid),
		.in_ready (fifo_out_ready),
		.in_data  (fifo_out_data),
		.busy     (ser_busy),
		.cfg_clk  (serial_cfg_clock),
		.cfg_dat  (serial_cfg_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Pin and indicator registers

	logic [1:0]  dctl_r;
	logic [15:0] dval_r;
	logic        we_prev_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			flash_addr_o   <= '0;
			flash_ce_n_o   <= 1'b1;
			flash_oe_n_o   <= 1'b1;
			flash_bus_oe_n <= 1'b1;
			tgt_config_n   <= 1'b1;
			leds           <= '0;
			chain          <= '0;
			disp           <= '0;
		end else begin
			flash_addr_o   <= faddr_r;
			flash_ce_n_o   <= !f_busy_r;
			flash_oe_n_o   <= !f_busy_r;
			flash_bus_oe_n <= !ser_en;
			tgt_config_n   <= (state_r != BCL_PULSE);
			leds.loading   <= !rest;
			leds.error     <= (state_r == BCL_FAIL);
			leds.factory   <= (state_r == BCL_GOOD) && fac_img_r;
			leds.user      <= (state_r == BCL_GOOD) && !fac_img_r;
			leds.sram_act  <= !sram_n_s;
			leds.flash_act <= f_busy_r || !tfce_n_s;
			chain.tgt_in   <= sw_s.tgt_byp;
			chain.pa_in    <= sw_s.pa_byp && !pa_pres_n_s;
			chain.pb_in    <= sw_s.pb_byp && !pb_pres_n_s;
			chain.ctrl_scan_en <= !sw_s.ctrl_dis;
			chain.cable_en     <= !sw_s.ctrl_dis;
			disp.override   <= dctl_r[`BCL_DC_OVR_BIT];
			disp.show_power <= dctl_r[`BCL_DC_OVR_BIT]
				? dctl_r[`BCL_DC_PWR_BIT] : sw_s.show_power;
			disp.value      <= dval_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Display registers on the shared bus

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			we_prev_r <= 1'b1;
			dctl_r    <= `BCL_DISP_CTRL_RST;
			dval_r    <= `BCL_DISP_VAL_RST;
		end else begin
			we_prev_r <= we_n_s;
			if (!cs_n_s && !we_prev_r && we_n_s && !ser_en) begin
				if (addr_s == `BCL_REG_DISP_CTRL)
					dctl_r <= d_s[1:0];
				else if (addr_s == `BCL_REG_DISP_VAL)
					dval_r <= d_s;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rd_data <= '0;
			reg_rd_oe_n <= 1'b1;
		end else begin
			reg_rd_oe_n <= !(!cs_n_s && !oe_n_s && !ser_en);
			unique case (addr_s)
				`BCL_REG_DISP_CTRL: reg_rd_data <= {14'h0, dctl_r};
				`BCL_REG_DISP_VAL:  reg_rd_data <= dval_r;
				`BCL_REG_STATUS:    reg_rd_data <= {10'h0, leds};
				default:            reg_rd_data <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_done_missing;
		(state_r == BCL_DWAIT) && (tmr_r == '0) && !done_s;
	endsequence

	sequence s_load_good;
		(state_r == BCL_GOOD) && !ctl_rst && !go;
	endsequence

	a_load_led_busy: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_r == BCL_LOAD) |=> leds.loading)
		else $error("loading indicator off while loading");

	a_done_timeout: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_done_missing and sw_s.loader_en and !ctl_rst
		|=> (state_r == BCL_FAIL) ##1 leds.error)
		else $error("missing done did not flag an error");

	a_factory_led: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_load_good and fac_img_r |=> leds.factory && !leds.user)
		else $error("factory indicator wrong");

	a_user_led: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_load_good and !fac_img_r |=> leds.user && !leds.factory)
		else $error("user indicator wrong");

	a_disabled_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
		!sw_s.loader_en && !rest |=> state_r == BCL_IDLE)
		else $error("loader ran while disabled");

	a_image_offset: assert property (@(posedge ref_clk) disable iff (!nrst)
		go && !go_fac |=>
		faddr_r == 26'({23'h0, $past(sel_s[2:0])} * IMG_STRIDE))
		else $error("wrong image start offset");

	a_factory_base: assert property (@(posedge ref_clk) disable iff (!nrst)
		go && go_fac |=> faddr_r == '0 && fac_img_r)
		else $error("factory load not from flash base");

	a_bad_select: assert property (@(posedge ref_clk) disable iff (!nrst)
		go && !go_fac && sel_s[3] |=> state_r == BCL_FAIL)
		else $error("invalid image position accepted");

	a_flash_led: assert property (@(posedge ref_clk) disable iff (!nrst)
		f_busy_r |=> leds.flash_act)
		else $error("flash activity indicator off during fetch");

	a_button_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
		ctl_rst |=> state_r == BCL_IDLE && start_pend_r)
		else $error("button did not reset the controller");

endmodule : bcl_top

// *** sim/bcl_far_model.sv ***
// Far-side model: parallel flash and the target's serial config port.
// Assumes word addresses from the loader and a registered serial clock.
`timescale 1ns/100ps
module bcl_far_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// Flash side
	input  wire logic [25:0] flash_addr_o,
	input  wire logic        flash_ce_n_o,
	input  wire logic        flash_oe_n_o,
	input  wire logic [15:0] host_d,
	output logic      [15:0] bus_d,
	// Target side
	input  wire logic        serial_cfg_clock,
	input  wire logic        serial_cfg_data,
	input  wire logic        tgt_config_n,
	input  wire logic        no_done,
	output logic             tgt_status_n,
	output logic             tgt_conf_done,
	output logic      [63:0] rx_bits
);
	logic [7:0] bit_n;
	logic [3:0] st_n;
	////////////////////////////////////////////////////////////////////////
	// Flash drives only while selected and read
	assign bus_d = (!flash_ce_n_o && !flash_oe_n_o) ?
		(flash_addr_o[15:0] ^ 16'h5a3c) : host_d;
	// Status low during the request, high a few cycles after it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_n <= 4'hf;
			tgt_status_n <= 1'b1;
			tgt_conf_done <= 1'b0;
		end else begin
			st_n <= !tgt_config_n ? 4'h0 : (st_n == 4'hf ? st_n : st_n + 4'h1);
			tgt_status_n <= tgt_config_n && st_n == 4'hf;
			tgt_conf_done <= bit_n == 8'h40 && !no_done;
		end
	end
	// Bits taken on the rising serial clock, first bit lowest
	always @(posedge serial_cfg_clock or negedge tgt_config_n or negedge nrst) begin
		if (!nrst || !tgt_config_n) begin
			bit_n <= 8'h00;
		end else begin
			rx_bits <= {serial_cfg_data, rx_bits[63:1]};
			bit_n <= bit_n + 8'h01;
		end
	end
endmodule : bcl_far_model

// *** sim/bcl_top_tb_top.sv ***
// Self-checking bench of the loader: loads, errors, switches, display.
// Assumes the far-side model and small image parameters.
`timescale 1ns/100ps
module bcl_top_tb_top;
	import bcl_pkg::*;
	logic ref_clk = 0, nrst = 0, rc_n = 1, fa_n = 1, no_done = 0, sck_d = 0;
	logic cs_n = 1, we_n = 1, oe_n = 1, pa_n = 1, pb_n = 1, sram_n = 1;
	logic sr_n = 1, tfc_n = 1, fboe;
	bcl_sw_t sw;
	logic [3:0] sel;
	logic [1:0] ra;
	logic [15:0] hd, bus_d, rdd;
	logic [25:0] faddr;
	logic fce, foe, sck, sd, cfgn, stn, cdone, rdoe;
	logic [63:0] rx;
	bcl_led_t leds;
	bcl_chain_t chain;
	bcl_disp_t disp;
	int n_fail = 0, checks_done = 0, cyc = 0, sck_n = 1;
	////////////////////////////////////////////////////////////////////////
	bcl_top #(.IMG_WORDS(24'h000004), .IMG_STRIDE(26'h0000010),
		.STATUS_TO(16'h0030)) DUT (
		.ref_clk(ref_clk), .nrst(nrst), .btn_reconf_n(rc_n),
		.btn_factory_n(fa_n), .btn_sysrst_n(sr_n), .sw_pins(sw),
		.img_sel_pins(sel), .pa_present_n(pa_n), .pb_present_n(pb_n),
		.bus_d_i(bus_d), .flash_addr_o(faddr), .flash_ce_n_o(fce),
		.flash_oe_n_o(foe), .flash_bus_oe_n(fboe), .tgt_flash_ce_n(tfc_n),
		.sram_ce_n(sram_n), .serial_cfg_clock(sck), .serial_cfg_data(sd),
		.tgt_config_n(cfgn), .tgt_status_n(stn), .tgt_conf_done(cdone),
		.reg_cs_n(cs_n), .reg_we_n(we_n), .reg_oe_n(oe_n), .reg_addr(ra),
		.reg_rd_data(rdd), .reg_rd_oe_n(rdoe), .leds(leds), .chain(chain),
		.disp(disp));
	bcl_far_model far (.ref_clk(ref_clk), .nrst(nrst), .flash_addr_o(faddr),
		.flash_ce_n_o(fce), .flash_oe_n_o(foe), .host_d(hd), .bus_d(bus_d),
		.serial_cfg_clock(sck), .serial_cfg_data(sd), .tgt_config_n(cfgn),
		.no_done(no_done), .tgt_status_n(stn), .tgt_conf_done(cdone),
		.rx_bits(rx));
	////////////////////////////////////////////////////////////////////////
	initial forever #5 ref_clk = ~ref_clk;
	task tally_and_finish;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wt
	task btn(input logic [1:0] f);
		if (f == 2'h1) fa_n = 0;
		else if (f == 2'h2) sr_n = 0;
		else rc_n = 0;
		wt(5);
		fa_n = 1;
		rc_n = 1;
		sr_n = 1;
	endtask : btn
	task load_chk(input logic [15:0] base, input logic fac);
		int k;
		for (k = 0; k < 500 && cfgn !== 1'b0; k++) wt(1);
		wt(3);
		chk(leds.loading === 1'b1, "not loading");
		for (k = 0; k < 500 && fce !== 1'b0; k++) wt(1);
		wt(2);
		chk(leds.flash_act === 1'b1 && fboe === 1'b0, "flash idle");
		for (k = 0; k < 4000 && leds.loading !== 1'b0; k++) wt(1);
		wt(3);
		for (k = 0; k < 4; k++) chk(rx[16*k+:16] === ((base + 16'(k)) ^ 16'h5a3c), "word");
		chk(leds.factory === fac && leds.user === !fac && !leds.error, "ind");
	endtask : load_chk
	task reg_io(input logic [1:0] a, input logic [15:0] d, input logic rd);
		ra = a;
		hd = d;
		cs_n = 0;
		if (rd) oe_n = 0; else we_n = 0;
		wt(5);
		if (rd) chk(rdoe === 1'b0 && rdd === d, "read");
		we_n = 1;
		oe_n = 1;
		wt(4);
		cs_n = 1;
		wt(3);
	endtask : reg_io
	always @(negedge ref_clk) begin
		cyc <= cyc + 1;
		sck_d <= sck;
		if (sck && !sck_d) begin
			chk(sck_n >= 9, "clock fast");
			sck_n <= 1;
		end else sck_n <= sck_n + 1;
		if (cyc == 40000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		int i;
		sw = '0;
		sw.loader_en = 1;
		sel = 4'h3;
		ra = 2'h0;
		hd = 16'h0000;
		wt(2);
		nrst = 1;
		load_chk(16'h0030, 1'b0);
		$display("test power-up load done");
		sw.loader_en = 0;
		btn(1'b1);
		wt(300);
		chk(cfgn === 1'b1, "ran while off");
		sw.loader_en = 1;
		load_chk(16'h0000, 1'b1);
		reg_io(2'h2, 16'h0008, 1'b1);
		$display("test factory load done");
		no_done = 1;
		btn(1'b0);
		wt(2500);
		chk(leds.error === 1'b1 && leds.user === 1'b0, "no error");
		no_done = 0;
		sel = 4'h9;
		btn(2'h2);
		wt(40);
		chk(leds.error === 1'b1 && cfgn === 1'b1, "bad select");
		sel = 4'h5;
		btn(1'b0);
		load_chk(16'h0050, 1'b0);
		btn(1'b1);
		wt(2);
		chk(cfgn === 1'b0, "no start");
		sw.loader_en = 0;
		wt(5);
		chk(leds.loading === 1'b0 && cfgn === 1'b1, "no abort");
		sw.loader_en = 1;
		$display("test error paths done");
		for (i = 0; i < 4; i++) begin
			sw.tgt_byp = i[0];
			sw.ctrl_dis = i[0];
			sw.pa_byp = i[1];
			sw.pb_byp = !i[1];
			sw.show_power = i[1];
			pa_n = i[0];
			pb_n = 0;
			sram_n = i[1];
			tfc_n = i[0];
			wt(6);
			chk(chain === {i[0], i[1] & !i[0], !i[1], !i[0], !i[0]}, "chain");
			chk(disp.show_power === i[1] && leds.sram_act === !i[1]
				&& leds.flash_act === !i[0], "disp");
		end
		reg_io(2'h1, 16'hbeef, 1'b0);
		reg_io(2'h0, 16'h0001, 1'b0);
		chk(disp === {1'b1, 1'b0, 16'hbeef}, "disp reg");
		reg_io(2'h1, 16'hbeef, 1'b1);
		$display("test switches and display done");
		tally_and_finish();
	end
endmodule : bcl_top_tb_top
